/* File: rtl/ebt_regs.vh */
/*
 Constants for the eight-bit timer/counter: field widths, reset values and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef EBT_REGS_VH
`define EBT_REGS_VH
`define EBT_COUNT_W 8
`define EBT_RATE_W 3
`define EBT_PRE_W 8
`define EBT_COUNT_RST 8'h00
`define EBT_PRE_RST 8'h00
`define EBT_COUNT_MAX 8'hFF
`define EBT_WR_INHIBIT 2'h2
`define EBT_PHASES 2
`define EBT_PH_Q2 2'h1
`define EBT_PH_Q4 2'h3
`endif

/* File: rtl/ebt_edge_detect.v */
/*
 Edge detector for one external count source.
 Assumes the source input is already synchronous to clk.
*/
`timescale 1ns/100ps
module ebt_edge_detect
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Source and edge choice
   input wire src,
   input wire falling,
   // Detected edge
   output wire edge_pulse
);
   reg prev_q;

   always @(posedge clk)
   begin
      if (rst)
         prev_q <= 1'b0;
      else
         prev_q <= src;
   end

   assign edge_pulse = falling ? (prev_q & ~src) : (~prev_q & src);
endmodule // ebt_edge_detect

/* File: rtl/ebt_prescaler.v */
/*
 Hidden binary prescaler for the timer; its count has no software path.
 Assumes tick is a one-cycle pulse and clear comes from a count register write.
*/
`timescale 1ns/100ps
`include "ebt_regs.vh"
module ebt_prescaler
#(
   parameter W = `EBT_PRE_W
)
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Control
   input wire tick,
   input wire clear,
   input wire [`EBT_RATE_W-1:0] rate,
   // Divided output level
   output wire div_out
);
   reg [W-1:0] cnt_q;
   wire [W-1:0] cnt_d;

   assign cnt_d = clear ? `EBT_PRE_RST : (tick ? cnt_q + {{(W-1){1'b0}}, 1'b1} : cnt_q);

   always @(posedge clk)
   begin
      if (rst)
         cnt_q <= `EBT_PRE_RST;
      else
         cnt_q <= cnt_d;
   end

   // Bit n toggles every 2^n ticks, so one rising edge of it per 2^(n+1)-tick ratio period.
   assign div_out = cnt_q[rate];
endmodule // ebt_prescaler

/* File: rtl/ebt_timer.v */
/*
 Eight-bit timer/counter with optional hidden prescaler and overflow flag.
 Assumes all inputs are synchronous to clk; one instruction cycle is one clk cycle,
 which stands for all four Q phases at once; no phase counter is kept.
*/
`timescale 1ns/100ps
`include "ebt_regs.vh"
module ebt_timer
#(
   parameter CW = `EBT_COUNT_W,
   parameter PW = `EBT_PRE_W
)
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Configuration bits
   input wire clock_source_select,
   input wire external_source_select,
   input wire source_edge_select,
   input wire prescaler_bypass,
   input wire [`EBT_RATE_W-1:0] prescale_rate,
   input wire overflow_int_enable,
   // Processor state
   input wire sleep,
   // Count register access
   input wire count_wr,
   input wire [CW-1:0] count_wdata,
   output wire [CW-1:0] count_register,
   // Overflow flag access
   input wire flag_clr,
   output wire overflow_flag,
   // External sources
   input wire external_count_pin,
   input wire cap_sense_osc_clock,
   // Outputs to the system
   output wire overflow_irq,
   output wire gate_source
);
   // Timing, one clk cycle per instruction cycle:
   // a write taken at edge c0 shows at once, edges c1 and c2 hold it, and edge c3
   // may count again. A wrap at edge c sets the flag and the gate pulse for the
   // cycle after c; the gate pulse lasts that one cycle, the flag until cleared.
   // External sources are taken as already synchronous, so an edge seen at one
   // edge is counted there when the prescaler is bypassed.
   // In sleep no source ticks, so the count and the prescaler both hold.

   // Count register and write hold.
   reg [CW-1:0] count_q;
   reg [CW-1:0] count_d;
   reg [CW-1:0] count_plus;
   reg [1:0] inhibit_q;
   reg [1:0] inhibit_d;
   // Overflow flag and the delayed wrap pulse for the gate output.
   reg flag_q;
   reg flag_d;
   reg wrap_q;
   // Divider output as sampled once per instruction cycle.
   reg div_samp_q;
   reg div_samp_d;
   // Mode decode, source selection and increment decisions.
   reg counter_mode;
   reg use_osc;
   reg ext_src;
   reg src_tick;
   reg inc;
   reg div_rise;
   reg wrap;
   wire ext_edge;
   wire pre_tick;
   wire div_out;
   wire count_run;

   // Mode bits decoded once.
   always @*
   begin
      counter_mode = clock_source_select;
      use_osc = clock_source_select & external_source_select;
   end

   // Counter mode chooses the pin or the oscillator signal.
   always @*
   begin
      if (use_osc)
      begin
         ext_src = cap_sense_osc_clock;
      end
      else
      begin
         ext_src = external_count_pin;
      end
   end

   // One detector serves both sources, so the edge choice applies to either.
   ebt_edge_detect i_ebt_edge_detect
   (
      .clk(clk),
      .rst(rst),
      .src(ext_src),
      .falling(source_edge_select),
      .edge_pulse(ext_edge)
   );

   // Timer mode ticks every cycle, counter mode on chosen edges; sleep stops both.
   always @*
   begin
      if (sleep)
      begin
         src_tick = 1'b0;
      end
      else if (counter_mode)
      begin
         src_tick = ext_edge;
      end
      else
      begin
         src_tick = 1'b1;
      end
   end

   // Ticks reach the prescaler only while it is in the path.
   assign pre_tick = src_tick & ~prescaler_bypass;

   // The prescaler belongs to this timer only; the watchdog keeps its own, and no
   // port reads or loads this count.
   ebt_prescaler #(.W(PW)) i_ebt_prescaler
   (
      .clk(clk),
      .rst(rst),
      .tick(pre_tick),
      .clear(count_wr),
      .rate(prescale_rate),
      .div_out(div_out)
   );

   // One clk cycle stands for a whole instruction cycle, which holds both Q2 and Q4,
   // so the divider output is resampled every cycle. Sampling in every other cycle
   // only would miss the divide-by-2 output, which is high in one cycle of two.
   always @*
   begin
      if (count_wr)
      begin
         div_samp_d = 1'b0;
      end
      else
      begin
         div_samp_d = div_out;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         div_samp_q <= 1'b0;
      end
      else
      begin
         div_samp_q <= div_samp_d;
      end
   end

   // A rising divider level marks one completed prescale period.
   always @*
   begin
      if (sleep)
      begin
         div_rise = 1'b0;
      end
      else
      begin
         div_rise = div_out & ~div_samp_q;
      end
   end

   // Bypass gives 1:1; otherwise one increment per divided period.
   always @*
   begin
      if (prescaler_bypass)
      begin
         inc = src_tick;
      end
      else
      begin
         inc = div_rise;
      end
   end

   // Counting is allowed once both cycles after a write have passed.
   assign count_run = (inhibit_q == 2'h0);

   // A write loads two cycles of hold, and each later cycle uses one.
   always @*
   begin
      if (count_wr)
      begin
         inhibit_d = `EBT_WR_INHIBIT;
      end
      else if (!count_run)
      begin
         inhibit_d = inhibit_q - 2'h1;
      end
      else
      begin
         inhibit_d = 2'h0;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         inhibit_q <= 2'h0;
      end
      else
      begin
         inhibit_q <= inhibit_d;
      end
   end

   // Next value for a counting cycle.
   always @*
   begin
      count_plus = count_q + {{(CW-1){1'b0}}, 1'b1};
   end

   // Increments that fall in the hold are dropped, not deferred.
   always @*
   begin
      if (count_wr)
      begin
         count_d = count_wdata;
      end
      else if (count_run && inc)
      begin
         count_d = count_plus;
      end
      else
      begin
         count_d = count_q;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         count_q <= `EBT_COUNT_RST;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   // An increment taken at the top value wraps the count to zero.
   always @*
   begin
      if (count_wr || !count_run || !inc)
      begin
         wrap = 1'b0;
      end
      else
      begin
         wrap = (count_q == `EBT_COUNT_MAX);
      end
   end

   // The gate pulse trails the wrap by one cycle.
   always @(posedge clk)
   begin
      if (rst)
      begin
         wrap_q <= 1'b0;
      end
      else
      begin
         wrap_q <= wrap;
      end
   end

   // Hardware only sets the flag, and a set in the clearing cycle wins, so a wrap
   // is never lost to a software clear that comes too late.
   always @*
   begin
      if (wrap)
      begin
         flag_d = 1'b1;
      end
      else if (flag_clr)
      begin
         flag_d = 1'b0;
      end
      else
      begin
         flag_d = flag_q;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end

   // Register values go out unchanged.
   assign count_register = count_q;
   assign overflow_flag = flag_q;

   // No wake path: the counter is frozen in sleep, so no overflow can occur there.
   assign overflow_irq = flag_q & overflow_int_enable & ~sleep;

   // The sixteen-bit timer may use this one-cycle wrap pulse as its gate.
   assign gate_source = wrap_q;
endmodule // ebt_timer

/* File: verification/ebt_src_model.sv */
/*
 External count source model: drives the count pin and the oscillator line.
 Assumes the bench calls burst between its own falling-edge input changes.
*/
`timescale 1ns/100ps
module ebt_src_model
(
   // Clock
   input wire clk,
   // Source lines, both idle low
   output logic external_count_pin,
   output logic cap_sense_osc_clock
);
   initial external_count_pin = 1'b0;
   initial cap_sense_osc_clock = 1'b0;
   // Gives n pin pulses and 2n oscillator pulses, so a wrong source choice shows.
   task automatic burst(input int n);
      for (int i = 0; i < 4 * n; i++)
      begin
         repeat (2) @(negedge clk);
         cap_sense_osc_clock = ~cap_sense_osc_clock;
         if (i % 2 == 0)
            external_count_pin = ~external_count_pin;
      end
   endtask
endmodule // ebt_src_model

/* File: verification/ebt_timer_chk.sv */
/*
 Port checker for the eight-bit timer/counter.
 Assumes binding to ebt_timer with its port names.
*/
`timescale 1ns/100ps
module ebt_timer_chk
(
   // Clock and reset
   input wire clk,
   input wire rst,
   // Configuration
   input wire clock_source_select,
   input wire prescaler_bypass,
   input wire overflow_int_enable,
   input wire sleep,
   // Count and flag
   input wire count_wr,
   input wire [7:0] count_wdata,
   input wire [7:0] count_register,
   input wire flag_clr,
   input wire overflow_flag,
   input wire overflow_irq,
   input wire gate_source
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_wr; count_wr ##1 !count_wr; endsequence
   sequence s_pre; !prescaler_bypass && !$past(prescaler_bypass) && !count_wr && !$past(count_wr); endsequence
   property p_inc; !clock_source_select && prescaler_bypass && !sleep && !count_wr && !$past(count_wr)
      && !$past(count_wr, 2) |=> count_register == $past(count_register) + 8'h01; endproperty
   a_inc: assert property (p_inc) else $error("timer missed an increment");
   property p_wr; s_wr |-> count_register == $past(count_wdata) ##1 $stable(count_register); endproperty
   a_wr: assert property (p_wr) else $error("write load or hold wrong");
   property p_wrap; !$past(rst) && !$past(count_wr) && $past(count_register) == 8'hFF
      && count_register == 8'h00 |-> overflow_flag && gate_source; endproperty
   a_wrap: assert property (p_wrap) else $error("wrap without flag");
   property p_hold; overflow_flag && !flag_clr |=> overflow_flag; endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_clr; flag_clr && count_register != 8'hFF |=> !overflow_flag; endproperty
   a_clr: assert property (p_clr) else $error("flag clear ignored");
   property p_irq; overflow_irq == (overflow_flag && overflow_int_enable && !sleep); endproperty
   a_irq: assert property (p_irq) else $error("irq wrong");
   property p_sleep; sleep && !count_wr |=> $stable(count_register); endproperty
   a_sleep: assert property (p_sleep) else $error("count moved in sleep");
   property p_pre; s_pre ##0 $changed(count_register) |=> $stable(count_register); endproperty
   a_pre: assert property (p_pre) else $error("prescaled count too fast");
   property p_gate; gate_source |=> !gate_source; endproperty
   a_gate: assert property (p_gate) else $error("gate pulse longer than one cycle");
endmodule // ebt_timer_chk
bind ebt_timer ebt_timer_chk i_ebt_timer_chk(.*);

/* File: verification/ebt_timer_test.sv */
/*
 Self-checking bench for the eight-bit timer/counter.
 Assumes the design, model and checker files are compiled first.
*/
`timescale 1ns/100ps
module ebt_timer_test;
   logic clk = 1'b0, rst = 1'b1, clock_source_select = 1'b0, external_source_select = 1'b0;
   logic source_edge_select = 1'b0, prescaler_bypass = 1'b1, overflow_int_enable = 1'b0, sleep = 1'b0;
   logic count_wr = 1'b0, flag_clr = 1'b0;
   logic [2:0] prescale_rate = 3'h0;
   logic [7:0] count_wdata = 8'h00;
   wire [7:0] count_register;
   wire overflow_flag, overflow_irq, gate_source, external_count_pin, cap_sense_osc_clock;
   int errors = 0, checked = 0, n;
   initial forever #2.5 clk = ~clk;
   ebt_src_model i_ebt_src_model(.*);
   ebt_timer i_ebt_timer(.*);
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
      checked++;
      if (v !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic end_sim;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic wrc(input logic [7:0] v);
      @(negedge clk);
      count_wr = 1'b1;
      count_wdata = v;
      @(negedge clk);
      count_wr = 1'b0;
   endtask
   // Cycles until the count next moves.
   task automatic gap(output int k);
      logic [7:0] c;
      c = count_register;
      k = 0;
      while (count_register === c && k < 600)
      begin
         cyc(1);
         k++;
      end
   endtask
   initial
   begin
      #200us;
      errors++;
      end_sim;
   end
   initial
   begin
      cyc(6);
      rst = 1'b0;
      wrc(8'hFE);
      chk("count", 8'hFE, count_register);
      cyc(1);
      chk("count", 8'hFE, count_register);
      cyc(1);
      chk("count", 8'hFE, count_register);
      cyc(1);
      chk("count", 8'hFF, count_register);
      cyc(1);
      chk("count", 8'h00, count_register);
      chk("flag", 1'b1, overflow_flag);
      chk("gate", 1'b1, gate_source);
      chk("irq", 1'b0, overflow_irq);
      overflow_int_enable = 1'b1;
      cyc(1);
      chk("irq", 1'b1, overflow_irq);
      sleep = 1'b1;
      n = count_register;
      cyc(5);
      chk("count", 16'(n), count_register);
      chk("irq", 1'b0, overflow_irq);
      sleep = 1'b0;
      flag_clr = 1'b1;
      cyc(1);
      flag_clr = 1'b0;
      chk("flag", 1'b0, overflow_flag);
      prescaler_bypass = 1'b0;
      for (int r = 0; r < 8; r++)
      begin
         prescale_rate = r[2:0];
         wrc(8'h00);
         gap(n);
         gap(n);
         chk("ratio", 16'(2 << r), 16'(n));
      end
      clock_source_select = 1'b1;
      prescaler_bypass = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         external_source_select = m[0];
         source_edge_select = m[1];
         wrc(8'h00);
         cyc(2);
         i_ebt_src_model.burst(3);
         cyc(4);
         chk("edges", m[0] ? 16'h6 : 16'h3, count_register);
      end
      // Four rising pin edges through the divide-by-2 prescaler give two counts.
      prescaler_bypass = 1'b0;
      prescale_rate = 3'h0;
      external_source_select = 1'b0;
      source_edge_select = 1'b0;
      wrc(8'h00);
      cyc(2);
      i_ebt_src_model.burst(4);
      cyc(4);
      chk("prescaled edges", 16'h2, count_register);
      end_sim;
   end
endmodule // ebt_timer_test
